// ==== verilog/eim_pkg.sv ====
// constants, types and helpers shared by the error interrupt mask unit
package eim_pkg;

  localparam int unsigned DATA_W   = 32;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DEST_W   = 16;
  localparam int unsigned LOCKOUT_RETRY_LIMIT_W   = 4;

  // register byte offsets in node space
  localparam logic [ADDR_W-1:0] OFS_ERR_MASK  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TARGET    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_SERVICE   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_UTILITY   = 8'h20;

  // error_interrupt_mask layout
  localparam logic [DATA_W-1:0] MASK_WRITABLE = 32'h89ff_afff;
  localparam logic [DATA_W-1:0] MASK_IRQ_SRC  = 32'h09ff_afff;
  localparam logic [DATA_W-1:0] MASK_RESET    = 32'h0000_0000;
  localparam int unsigned       BIT_IV_ENABLE = 31;
  localparam int unsigned       BIT_MASK_COR  = 10;
  localparam int unsigned       BIT_MASK_UNC  = 9;

  // source bits that line up with their mask bit
  localparam logic [DATA_W-1:0] BUSERR_DIRECT = 32'h09ff_a000;
  localparam logic [DATA_W-1:0] SUMMARY_DIRECT = 32'h0000_09ff;
  localparam int unsigned       SUM_COR_MAP   = 13;
  localparam int unsigned       SUM_COR_DMA   = 10;
  localparam int unsigned       SUM_UNC_MAP   = 12;
  localparam int unsigned       SUM_UNC_DMA   = 9;

  // interrupt_target_mask and utility_config layout
  localparam logic [DATA_W-1:0] TARGET_RESET  = 32'h0000_0000;
  localparam int unsigned       LOCKOUT_RETRY_LIMIT_LSB      = 28;
  localparam logic [LOCKOUT_RETRY_LIMIT_W-1:0] LOCKOUT_RETRY_LIMIT_RESET    = 4'h4;
  localparam logic [DATA_W-1:0] READ_ZERO     = 32'h0000_0000;

  typedef enum logic [1:0] {
    EIM_LK_IDLE   = 2'b00,
    EIM_LK_RETRY  = 2'b01,
    EIM_LK_LOCKED = 2'b10
  } eim_lock_state_t;

  // map both status registers onto the mask bit positions
  function automatic logic [DATA_W-1:0] eim_cause(
    input logic [DATA_W-1:0] bus_err,
    input logic [DATA_W-1:0] summary
  );
    logic [DATA_W-1:0] c;
    c = (bus_err & BUSERR_DIRECT) // [R1] [R2] [R3] [R4]
      | (summary & SUMMARY_DIRECT); // [R6] [R9] [R10] [R11]
    c[BIT_MASK_COR] = summary[SUM_COR_MAP] | summary[SUM_COR_DMA]; // [R7]
    c[BIT_MASK_UNC] = summary[SUM_UNC_MAP] | summary[SUM_UNC_DMA]; // [R8]
    return c;
  endfunction

  // limit field to interlocked read attempts: 0 still allows one
  function automatic logic [LOCKOUT_RETRY_LIMIT_W-1:0] eim_attempts(
    input logic [LOCKOUT_RETRY_LIMIT_W-1:0] limit
  );
    return (limit == 4'h0) ? 4'h1 : limit;
  endfunction

endpackage

// ==== verilog/eim_core_if.sv ====
// carrier between the register hub, the interrupt gate and the lockout
`timescale 1ns/1ps
interface eim_core_if;
  logic [eim_pkg::DATA_W-1:0] mask;
  logic [eim_pkg::DATA_W-1:0] bus_err;
  logic [eim_pkg::DATA_W-1:0] summary;
  logic                       irq;
  logic [eim_pkg::DATA_W-1:0] pending;
  logic [eim_pkg::LOCKOUT_RETRY_LIMIT_W-1:0] limit;
  logic                       retry;
  logic                       done;
  logic                       clear;
  logic                       lockout;
  logic [eim_pkg::LOCKOUT_RETRY_LIMIT_W-1:0] count;

  modport hub (output mask, bus_err, summary, limit, retry, done, clear,
               input  irq, pending, lockout, count);
  modport gate (input mask, bus_err, summary, output irq, pending);
  modport lock (input limit, retry, done, clear, output lockout, count);
endinterface

// ==== verilog/eim_gate.sv ====
// error interrupt gating of status bits by the mask register
`timescale 1ns/1ps
module eim_gate (
  input  wire logic clk_in,
  input  wire logic rst_in,
  eim_core_if.gate  core
);

  logic [eim_pkg::DATA_W-1:0] pending_d;

  always_comb begin
    pending_d = eim_pkg::eim_cause(core.bus_err, core.summary)
              & core.mask & eim_pkg::MASK_IRQ_SRC;
  end

  // level request: stays up while any enabled status bit stays set
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      core.irq     <= 1'b0;
      core.pending <= eim_pkg::READ_ZERO;
    end else begin
      core.irq     <= |pending_d; // [R21]
      core.pending <= pending_d;
    end
  end

endmodule

// ==== verilog/eim_lockout.sv ====
// consecutive interlocked read retry counter driving the lockout request
`timescale 1ns/1ps
module eim_lockout (
  input  wire logic clk_in,
  input  wire logic rst_in,
  eim_core_if.lock  core
);

  eim_pkg::eim_lock_state_t   state_q;
  logic [eim_pkg::LOCKOUT_RETRY_LIMIT_W-1:0] next_cnt;

  always_comb begin
    next_cnt = core.count + 4'h1;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || core.clear) begin
      state_q      <= eim_pkg::EIM_LK_IDLE;
      core.count   <= '0;
      core.lockout <= 1'b0;
    end else begin
      case (state_q)
        eim_pkg::EIM_LK_IDLE, eim_pkg::EIM_LK_RETRY: begin
          if (core.done) begin
            state_q    <= eim_pkg::EIM_LK_IDLE;
            core.count <= '0;
          end else if (core.retry) begin
            core.count <= next_cnt;
            // attempts used up: claim the bus by lockout
            if (next_cnt >= eim_pkg::eim_attempts(core.limit)) begin
              state_q      <= eim_pkg::EIM_LK_LOCKED; // [R18]
              core.lockout <= 1'b1;
            end else begin
              state_q <= eim_pkg::EIM_LK_RETRY;
            end
          end
        end
        eim_pkg::EIM_LK_LOCKED: begin
          if (core.done) begin
            state_q      <= eim_pkg::EIM_LK_IDLE;
            core.count   <= '0;
            core.lockout <= 1'b0;
          end
        end
        default: begin
          state_q      <= eim_pkg::EIM_LK_IDLE;
          core.count   <= '0;
          core.lockout <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ==== verilog/eim_top.sv ====
// error interrupt mask unit: registers, interrupt gating, lockout limit
//
// Notes on behaviour
// [R1] mask 27,24,23 gate bus error bits
// [R2] mask 22,21,20 gate bus error bits
// [R3] mask 19,18,17 gate bus error bits
// [R4] mask 16,15,13 gate bus error bits
// [R5] reserved mask bits read zero, software writes zero
// [R6] mask 11 gates invalid page frame summary
// [R7] mask 10 gates correctable ecc, summary 13/10
// [R8] mask 9 gates uncorrectable ecc, summary 12/9
// [R9] mask 8,7,6 gate same summary bits
// [R10] mask 5,4,3 gate same summary bits
// [R11] mask 2,1,0 gate same summary bits
// [R12] low sixteen target bits select nodes
// [R13] any number of target nodes together
// [R14] software writes upper target bits zero
// [R15] target register keeps all 32 bits
// [R16] diagnostics raise priority above 30 first
// [R17] software never touches service diagnostic register
// [R18] limit field sets retries before lockout
// [R19] limit loads 4 at reset, any value
// [R20] vector interrupts need enable bit and targets
// [R21] request holds while status and mask set
`timescale 1ns/1ps
module eim_top (
  input  wire logic                       clk_in,
  input  wire logic                       rst_in,
  input  wire logic                       node_reset_in,
  input  wire logic [eim_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  input  wire logic [eim_pkg::DATA_W-1:0] reg_wdata_in,
  output logic      [eim_pkg::DATA_W-1:0] reg_rdata_out,
  output logic                            reg_ack_out,
  input  wire logic [eim_pkg::DATA_W-1:0] bus_error_register_in,
  input  wire logic [eim_pkg::DATA_W-1:0] error_summary_register_in,
  output logic                            err_irq_out,
  input  wire logic                       vector_event_in,
  output logic                            vector_valid_out,
  input  wire logic                       vector_ready_in,
  output logic      [eim_pkg::DEST_W-1:0] vector_dest_out,
  input  wire logic                       interlocked_retry_in,
  input  wire logic                       interlocked_done_in,
  output logic                            lockout_out
);

  logic [eim_pkg::DATA_W-1:0] error_interrupt_mask_q;
  logic [eim_pkg::DATA_W-1:0] interrupt_target_mask_q;
  logic [eim_pkg::LOCKOUT_RETRY_LIMIT_W-1:0] lockout_retry_limit_q;
  logic [eim_pkg::DATA_W-1:0] rdata_d;
  logic                       vector_pending_q;
  logic                       vector_enabled;
  logic                       init_reset;
  logic                       wr_mask;
  logic                       wr_target;
  logic                       wr_util;

  eim_core_if core ();

  assign init_reset = rst_in || node_reset_in;
  assign wr_mask    = reg_wr_in && (reg_addr_in == eim_pkg::OFS_ERR_MASK);
  assign wr_target  = reg_wr_in && (reg_addr_in == eim_pkg::OFS_TARGET);
  assign wr_util    = reg_wr_in && (reg_addr_in == eim_pkg::OFS_UTILITY);

  assign core.mask    = error_interrupt_mask_q;
  assign core.bus_err = bus_error_register_in;
  assign core.summary = error_summary_register_in;
  assign core.limit   = lockout_retry_limit_q;
  assign core.retry   = interlocked_retry_in;
  assign core.done    = interlocked_done_in;
  assign core.clear   = node_reset_in;

  eim_gate u_gate (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .core   (core.gate)
  );

  eim_lockout u_lockout (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .core   (core.lock)
  );

  assign err_irq_out = core.irq;
  assign lockout_out = core.lockout;

  // node reset also drops the vector enable, as a power-up does
  always_ff @(posedge clk_in) begin
    if (init_reset) begin
      error_interrupt_mask_q <= eim_pkg::MASK_RESET;
    end else if (wr_mask) begin
      error_interrupt_mask_q <= reg_wdata_in & eim_pkg::MASK_WRITABLE; // [R5]
    end
  end

  // all 32 bits kept for data path tests; only the low half is used
  always_ff @(posedge clk_in) begin
    if (init_reset) begin
      interrupt_target_mask_q <= eim_pkg::TARGET_RESET;
    end else if (wr_target) begin
      interrupt_target_mask_q <= reg_wdata_in; // [R15]
    end
  end

  always_ff @(posedge clk_in) begin
    if (init_reset) begin
      lockout_retry_limit_q <= eim_pkg::LOCKOUT_RETRY_LIMIT_RESET; // [R19]
    end else if (wr_util) begin
      lockout_retry_limit_q <=
        reg_wdata_in[eim_pkg::LOCKOUT_RETRY_LIMIT_LSB +: eim_pkg::LOCKOUT_RETRY_LIMIT_W]; // [R19]
    end
  end

  // read mux; service register shows the gated sources as registered on the last clock
  always_comb begin
    case (reg_addr_in)
      eim_pkg::OFS_ERR_MASK: rdata_d = error_interrupt_mask_q;
      eim_pkg::OFS_TARGET:   rdata_d = interrupt_target_mask_q;
      eim_pkg::OFS_SERVICE:  rdata_d = core.pending;
      eim_pkg::OFS_UTILITY: begin
        rdata_d = eim_pkg::READ_ZERO;
        rdata_d[eim_pkg::LOCKOUT_RETRY_LIMIT_LSB +: eim_pkg::LOCKOUT_RETRY_LIMIT_W] =
          lockout_retry_limit_q;
      end
      default:               rdata_d = eim_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= eim_pkg::READ_ZERO;
      reg_ack_out   <= 1'b0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rdata_d : eim_pkg::READ_ZERO;
      reg_ack_out   <= reg_rd_in || reg_wr_in;
    end
  end

  // without any target node a vector interrupt would go nowhere
  assign vector_enabled =
    error_interrupt_mask_q[eim_pkg::BIT_IV_ENABLE] &&
    (|interrupt_target_mask_q[eim_pkg::DEST_W-1:0]); // [R20]

  // a new event in the cycle of acceptance keeps the request pending
  always_ff @(posedge clk_in) begin
    if (init_reset || !vector_enabled) begin
      vector_pending_q <= 1'b0; // [R20]
    end else if (vector_event_in) begin
      vector_pending_q <= 1'b1;
    end else if (vector_ready_in) begin
      vector_pending_q <= 1'b0;
    end
  end

  assign vector_valid_out = vector_pending_q;

  // one transaction reaches every selected node at once
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      vector_dest_out <= '0;
    end else begin
      vector_dest_out <=
        interrupt_target_mask_q[eim_pkg::DEST_W-1:0]; // [R12] [R13]
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_bus_err_high;
    (error_interrupt_mask_q[27] && bus_error_register_in[27]) ||
    (error_interrupt_mask_q[24] && bus_error_register_in[24]) ||
    (error_interrupt_mask_q[23] && bus_error_register_in[23])
    |=> err_irq_out;
  endproperty
  a_bus_err_high: assert property (p_bus_err_high) // [R1]
    else $error("upper bus error source missed");

  property p_bus_err_seq;
    (error_interrupt_mask_q[22:20] & bus_error_register_in[22:20]) != 3'h0
    |=> err_irq_out;
  endproperty
  a_bus_err_seq: assert property (p_bus_err_seq) // [R2]
    else $error("bus error source 22..20 missed");

  property p_bus_err_read;
    ((error_interrupt_mask_q[19:17] & bus_error_register_in[19:17]) != 3'h0
     && !node_reset_in)[*2] |=> err_irq_out;
  endproperty
  a_bus_err_read: assert property (p_bus_err_read) // [R3]
    else $error("bus error source 19..17 missed");

  property p_bus_err_tto;
    error_interrupt_mask_q[13] && bus_error_register_in[13]
    |=> err_irq_out;
  endproperty
  a_bus_err_tto: assert property (p_bus_err_tto) // [R4]
    else $error("timeout source missed");

  property p_reserved_zero;
    !error_interrupt_mask_q[14] && !error_interrupt_mask_q[12] &&
    (!(reg_ack_out && $past(reg_rd_in) &&
       $past(reg_addr_in) == eim_pkg::OFS_ERR_MASK) ||
     (reg_rdata_out[14] == 1'b0 && reg_rdata_out[12] == 1'b0));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // [R5]
    else $error("reserved mask bit not zero");

  property p_ipfn;
    error_interrupt_mask_q[11] && error_summary_register_in[11]
    |=> err_irq_out;
  endproperty
  a_ipfn: assert property (p_ipfn) // [R6]
    else $error("page frame source missed");

  property p_cor_ecc;
    error_interrupt_mask_q[10] && error_summary_register_in[13]
    |=> err_irq_out;
  endproperty
  a_cor_ecc: assert property (p_cor_ecc) // [R7]
    else $error("correctable ecc from map missed");

  property p_unc_ecc;
    error_interrupt_mask_q[9] && error_summary_register_in[12]
    |=> err_irq_out;
  endproperty
  a_unc_ecc: assert property (p_unc_ecc) // [R8]
    else $error("uncorrectable ecc from map missed");

  property p_summary_mid;
    (error_interrupt_mask_q[8:6] & error_summary_register_in[8:6]) != 3'h0
    |=> err_irq_out;
  endproperty
  a_summary_mid: assert property (p_summary_mid) // [R9]
    else $error("summary source 8..6 missed");

  property p_summary_low;
    (error_interrupt_mask_q[5:0] & error_summary_register_in[5:0]) != 6'h0
    |=> err_irq_out;
  endproperty
  a_summary_low: assert property (p_summary_low) // [R10] [R11]
    else $error("summary source 5..0 missed");

  property p_irq_quiet;
    ((eim_pkg::eim_cause(bus_error_register_in, error_summary_register_in)
      & error_interrupt_mask_q & eim_pkg::MASK_IRQ_SRC) == 32'h0000_0000)
    |=> !err_irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) // [R21]
    else $error("interrupt without enabled source");

  property p_dest;
    vector_valid_out && $stable(interrupt_target_mask_q)
    |-> vector_dest_out == interrupt_target_mask_q[15:0];
  endproperty
  a_dest: assert property (p_dest) // [R12]
    else $error("destination differs from target mask");

  property p_target_rw;
    wr_target && !node_reset_in
    |=> interrupt_target_mask_q == $past(reg_wdata_in);
  endproperty
  a_target_rw: assert property (p_target_rw) // [R15]
    else $error("target mask lost written bits");

  property p_limit_reset;
    disable iff (1'b0)
    rst_in |=> lockout_retry_limit_q == 4'h4;
  endproperty
  a_limit_reset: assert property (p_limit_reset) // [R19]
    else $error("limit not 4 after reset");

  property p_lockout_cause;
    $rose(lockout_out) |->
    $past(interlocked_retry_in) &&
    $past(core.count) + 4'h1 >= eim_pkg::eim_attempts($past(core.limit));
  endproperty
  a_lockout_cause: assert property (p_lockout_cause) // [R18]
    else $error("lockout without enough retries");

  property p_lockout_hold;
    lockout_out && !interlocked_done_in && !node_reset_in
    |=> lockout_out;
  endproperty
  a_lockout_hold: assert property (p_lockout_hold) // [R18]
    else $error("lockout dropped early");

  property p_vector_gate;
    vector_valid_out |-> $past(error_interrupt_mask_q[31]);
  endproperty
  a_vector_gate: assert property (p_vector_gate) // [R20]
    else $error("vector interrupt while disabled");

  property p_bus_err_mid;
    (error_interrupt_mask_q[16:15] & bus_error_register_in[16:15]) != 2'h0
    |=> err_irq_out;
  endproperty
  a_bus_err_mid: assert property (p_bus_err_mid) // [R4]
    else $error("bus error source 16..15 missed");

  property p_cor_ecc_dma;
    error_interrupt_mask_q[10] && error_summary_register_in[10]
    |=> err_irq_out;
  endproperty
  a_cor_ecc_dma: assert property (p_cor_ecc_dma) // [R7]
    else $error("correctable ecc from dma missed");

  property p_unc_ecc_dma;
    error_interrupt_mask_q[9] && error_summary_register_in[9]
    |=> err_irq_out;
  endproperty
  a_unc_ecc_dma: assert property (p_unc_ecc_dma) // [R8]
    else $error("uncorrectable ecc from dma missed");

  property p_target_read;
    reg_ack_out && $past(reg_rd_in) &&
    $past(reg_addr_in) == eim_pkg::OFS_TARGET
    |-> reg_rdata_out == $past(interrupt_target_mask_q);
  endproperty
  a_target_read: assert property (p_target_read) // [R15]
    else $error("target mask read differs");

  property p_limit_read;
    reg_ack_out && $past(reg_rd_in) &&
    $past(reg_addr_in) == eim_pkg::OFS_UTILITY
    |-> reg_rdata_out == {$past(lockout_retry_limit_q), 28'h000_0000};
  endproperty
  a_limit_read: assert property (p_limit_read) // [R18]
    else $error("limit field read differs");

  property p_vector_hold;
    vector_valid_out && !vector_ready_in && vector_enabled && !node_reset_in
    |=> vector_valid_out;
  endproperty
  a_vector_hold: assert property (p_vector_hold) // [R20]
    else $error("vector interrupt dropped before acceptance");

  property p_dest_follow;
    vector_dest_out == $past(interrupt_target_mask_q[15:0]);
  endproperty
  a_dest_follow: assert property (p_dest_follow) // [R13]
    else $error("destination lags target by more than a cycle");

endmodule

// ==== verification/eim_node_model.sv ====
// system bus node model that accepts implied vector interrupts
`timescale 1ns/1ps
module eim_node_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        valid_in,
  input  wire logic [15:0] dest_in,
  input  wire logic [3:0]  stall_in,
  output logic             ready_out,
  output logic [15:0]      dest_out,
  output logic [7:0]       count_out
);
  logic [3:0] wait_q;

  // ready is a single pulse; an offer withdrawn meanwhile restarts the stall
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ready_out <= 1'b0;
      wait_q    <= 4'h0;
      dest_out  <= 16'h0000;
      count_out <= 8'h00;
    end else if (!valid_in) begin
      ready_out <= 1'b0;
      wait_q    <= 4'h0;
    end else if (ready_out) begin
      ready_out <= 1'b0;
      wait_q    <= 4'h0;
      dest_out  <= dest_in;
      count_out <= count_out + 8'h01;
    end else if (wait_q >= stall_in) begin
      ready_out <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// ==== verification/eim_top_bench.sv ====
// self-checking bench for the error interrupt mask unit
`timescale 1ns/1ps
module eim_top_bench;
  localparam logic [31:0] SRC = 32'h09ff_afff;
  logic        clk_in     = 1'b0;
  logic        rst_in     = 1'b1;
  logic        node_reset = 1'b0;
  logic [7:0]  addr       = 8'h00;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [31:0] wdata      = 32'h0;
  logic [31:0] be         = 32'h0;
  logic [31:0] sm         = 32'h0;
  logic        ev         = 1'b0;
  logic        retry      = 1'b0;
  logic        done       = 1'b0;
  logic [3:0]  stall      = 4'h0;
  logic [31:0] rdata;
  logic        ack;
  logic        irq;
  logic        valid;
  logic        ready;
  logic [15:0] dest;
  logic        lockout;
  logic [15:0] got_dest;
  logic [7:0]  got_cnt;
  logic [3:0]  lims [4] = '{4'h0, 4'h1, 4'h4, 4'hf};
  int          bad_count = 0;
  int          tests_run = 0;
  int          s;
  int          att;

  always #2.5 clk_in = ~clk_in;

  eim_top u_dut (
    .clk_in                    (clk_in),
    .rst_in                    (rst_in),
    .node_reset_in             (node_reset),
    .reg_addr_in               (addr),
    .reg_wr_in                 (wr),
    .reg_rd_in                 (rd),
    .reg_wdata_in              (wdata),
    .reg_rdata_out             (rdata),
    .reg_ack_out               (ack),
    .bus_error_register_in     (be),
    .error_summary_register_in (sm),
    .err_irq_out               (irq),
    .vector_event_in           (ev),
    .vector_valid_out          (valid),
    .vector_ready_in           (ready),
    .vector_dest_out           (dest),
    .interlocked_retry_in      (retry),
    .interlocked_done_in       (done),
    .lockout_out               (lockout)
  );

  eim_node_model u_node (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .valid_in  (valid),
    .dest_in   (dest),
    .stall_in  (stall),
    .ready_out (ready),
    .dest_out  (got_dest),
    .count_out (got_cnt)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    @(negedge clk_in);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    chk({31'h0, ack}, 32'h1);
    chk(rdata, exp);
  endtask

  task automatic status(input int b, input logic to_sum, input logic on);
    @(posedge clk_in);
    be <= (on && !to_sum) ? 32'h1 << b : 32'h0;
    sm <= (on && to_sum) ? 32'h1 << b : 32'h0;
  endtask

  task automatic pulse_retry(input int n);
    if (n > 0) begin
      @(posedge clk_in);
      retry <= 1'b1;
      repeat (n) @(posedge clk_in);
      retry <= 1'b0;
    end
    @(negedge clk_in);
  endtask

  // waits a bounded span for the node model to take the interrupt
  task automatic fire(input logic [15:0] exp, input logic take);
    logic [7:0] c0;
    c0 = got_cnt;
    @(posedge clk_in);
    ev <= 1'b1;
    @(posedge clk_in);
    ev <= 1'b0;
    for (int n = 0; n < 24 && got_cnt == c0; n++) @(posedge clk_in);
    tick(1);
    chk({24'h0, got_cnt - c0}, {31'h0, take});
    if (take) chk({16'h0, got_dest}, {16'h0, exp});
    chk({31'h0, valid}, 32'h0);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test;
  end

  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    rd_chk(8'h14, 32'h0);
    rd_chk(8'h18, 32'h0);
    rd_chk(8'h20, 32'h4000_0000);
    rd_chk(8'h40, 32'h0);
    $display("test reset_values done");

    wr_reg(8'h14, 32'hffff_ffff);
    rd_chk(8'h14, 32'h89ff_afff);
    wr_reg(8'h14, 32'h0);
    // pattern test runs with a clear mask, so no vector can escape
    wr_reg(8'h18, 32'ha5c3_5a3c);
    rd_chk(8'h18, 32'ha5c3_5a3c);
    wr_reg(8'h20, 32'hffff_ffff);
    rd_chk(8'h20, 32'hf000_0000);
    wr_reg(8'h1c, 32'hffff_ffff);
    rd_chk(8'h1c, 32'h0);
    $display("test register_access done");

    // 9 and 10 are also reached from summary bits three places up
    for (int i = 0; i < 32; i++) begin
      for (int k = 0; k < 2; k++) begin
        if (SRC[i] && (k == 0 || i == 9 || i == 10)) begin
          s = (k == 0) ? i : i + 3;
          status(s, i < 13, 1'b1);
          tick(2);
          chk({31'h0, irq}, 32'h0);
          wr_reg(8'h14, 32'h1 << i);
          tick(1);
          chk({31'h0, irq}, 32'h1);
          status(s, i < 13, 1'b0);
          tick(1);
          chk({31'h0, irq}, 32'h0);
          wr_reg(8'h14, 32'h0);
        end
      end
    end
    $display("test interrupt_gating done");

    for (int j = 0; j < 4; j++) begin
      wr_reg(8'h20, {lims[j], 28'h0});
      att = (lims[j] == 4'h0) ? 1 : int'(lims[j]);
      pulse_retry(att - 1);
      chk({31'h0, lockout}, 32'h0);
      pulse_retry(1);
      chk({31'h0, lockout}, 32'h1);
      pulse_retry(3);
      chk({31'h0, lockout}, 32'h1);
      @(posedge clk_in);
      done <= 1'b1;
      @(posedge clk_in);
      done <= 1'b0;
      tick(0);
      chk({31'h0, lockout}, 32'h0);
    end
    $display("test lockout_limit done");

    // upper target bits kept zero when used as a node mask
    wr_reg(8'h18, 32'h0000_8005);
    wr_reg(8'h14, 32'h8000_0000);
    stall = 4'h0;
    fire(16'h8005, 1'b1);
    stall = 4'h6;
    wr_reg(8'h18, 32'h0000_0003);
    fire(16'h0003, 1'b1);
    wr_reg(8'h14, 32'h0);
    fire(16'h0, 1'b0);
    wr_reg(8'h14, 32'h8000_0000);
    wr_reg(8'h18, 32'h0);
    fire(16'h0, 1'b0);
    $display("test vector_interrupt done");

    @(posedge clk_in);
    node_reset <= 1'b1;
    @(posedge clk_in);
    node_reset <= 1'b0;
    tick(0);
    rd_chk(8'h20, 32'h4000_0000);
    rd_chk(8'h14, 32'h0);
    $display("test node_reset done");
    stop_test;
  end
endmodule
